// ### sfe_regs.svh
// Constants shared by the serial flash erase and sleep ends.
`ifndef SFE_REGS_SVH
`define SFE_REGS_SVH
`define SFE_OP_UNLOCK 8'h06
`define SFE_OP_LOCK 8'h04
`define SFE_OP_SMALL_WIPE 8'h20
`define SFE_OP_WIPE32 8'h52
`define SFE_OP_WIPE64 8'hD8
`define SFE_OP_FULL_A 8'h60
`define SFE_OP_FULL_B 8'hC7
`define SFE_OP_LOWEST 8'hB9
`define SFE_OP_WAKE 8'hAB
`define SFE_OP_RST_EN 8'h66
`define SFE_OP_RST 8'h99
`define SFE_OP_BITS 6'h08
`define SFE_ADDR_BITS 6'h20
`define SFE_BIT_SAT 6'h21
`define SFE_OP_MSB 31
`define SFE_OP_LSB 24
`define SFE_MEM_TOP 19
`define SFE_B64_LSB 16
`define SFE_BLOCKS 5'h10
`define SFE_LVL_ALL 3'h5
`define SFE_MASK_4K 20'h00FFF
`define SFE_MASK_32K 20'h07FFF
`define SFE_MASK_64K 20'h0FFFF
`define SFE_MASK_ALL 20'hFFFFF
`define SFE_CLK_MHZ 200
`define SFE_NS_PER_US 1000
`define SFE_SMALL_WIPE_US 50000
`define SFE_BLOCK_WIPE_US 150000
`define SFE_FULL_WIPE_US 2000000
`define SFE_SLEEP_ENTRY_NS 3000
`define SFE_RELEASE_NS 3000
`define SFE_GAP_NS 100
`define SFE_HALF_CYC 8
`define SFE_REG_CMD 4'h0
`define SFE_REG_ADDR 4'h4
`define SFE_REG_STAT 4'h8
`define SFE_CMD_WITH_ADDR 8
`define SFE_RESP_OK 2'h0
`define SFE_RESP_ERR 2'h2
`endif

// ### sfe_pkg.sv
// Types shared by the serial flash erase and sleep ends.
package sfe_pkg;
  typedef enum logic [1:0] {SFE_W4K, SFE_W32K, SFE_W64K, SFE_WALL} sfe_wipe_type;
  typedef enum logic [1:0] {SFE_STANDBY, SFE_WIPING, SFE_SLEEP_WAIT, SFE_SLEEPING} sfe_dev_type;
  typedef enum logic [2:0] {SFE_H_IDLE, SFE_H_LOW, SFE_H_HIGH, SFE_H_TAIL, SFE_H_GAP} sfe_host_type;
endpackage : sfe_pkg

// ### sfe_link_if.sv
// Three-wire serial link between host controller and flash device.
interface sfe_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  modport host (
    output cs_n,
    output sclk,
    output si
  );
  modport flash (
    input cs_n,
    input sclk,
    input si
  );
endinterface : sfe_link_if

// ### sfe_sync.sv
// Two-stage synchroniser for link pins entering the core clock domain.
module sfe_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input logic aclk, // Core clock.
  input logic aresetn, // Synchronous reset, active low.
  input logic [W-1:0] d, // Asynchronous inputs.
  output logic [W-1:0] q // Synchronised outputs.
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      sync_ff <= meta_ff;
    end
  end

  assign q = sync_ff;
endmodule : sfe_sync

// ### sfe_flash_dev.sv
// Flash device end: erase decoding, protection, busy timing and deep power-down.
`include "sfe_regs.svh"
module sfe_flash_dev #(
  parameter int CLK_MHZ = `SFE_CLK_MHZ,
  parameter int SMALL_WIPE_US = `SFE_SMALL_WIPE_US,
  parameter int BLOCK_WIPE_US = `SFE_BLOCK_WIPE_US,
  parameter int FULL_WIPE_US = `SFE_FULL_WIPE_US,
  parameter int SLEEP_ENTRY_NS = `SFE_SLEEP_ENTRY_NS
) (
  input logic aclk, // Core clock.
  input logic aresetn, // Synchronous reset, active low; stands for power-up.
  sfe_link_if.flash link, // Serial link from the host.
  input logic [4:0] protect_level_bits, // Block protect level setting.
  input logic protect_complement, // Inverts the protected area.
  output logic busy_flag, // High while an erase cycle runs.
  output logic write_latch_flag, // Write latch state.
  output logic asleep, // High while in deep power-down.
  output logic wipe_start, // One-cycle pulse when an erase begins.
  output logic [1:0] wipe_kind, // Kind of the erase last started.
  output logic [19:0] wipe_base // Aligned base of the erase last started.
);
  localparam int SMALL_CYC = SMALL_WIPE_US * CLK_MHZ;
  localparam int BLOCK_CYC = BLOCK_WIPE_US * CLK_MHZ;
  localparam int FULL_CYC = FULL_WIPE_US * CLK_MHZ;
  localparam int SLEEP_CYC = (SLEEP_ENTRY_NS * CLK_MHZ + `SFE_NS_PER_US - 1) / `SFE_NS_PER_US;

  if (SMALL_CYC < 1 || BLOCK_CYC < 1 || FULL_CYC < 1 || SLEEP_CYC < 1) begin : g_chk
    $error("sfe_flash_dev: every timed interval needs at least one cycle");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [19:0] unit_mask(input sfe_pkg::sfe_wipe_type k);
    logic [19:0] m;
    m = `SFE_MASK_ALL;
    case (k)
      sfe_pkg::SFE_W4K: m = `SFE_MASK_4K;
      sfe_pkg::SFE_W32K: m = `SFE_MASK_32K;
      sfe_pkg::SFE_W64K: m = `SFE_MASK_64K;
      default: m = `SFE_MASK_ALL;
    endcase
    return m;
  endfunction : unit_mask

  // Protection works in 64KB blocks, from the top or, with level bit 3, the bottom.
  function automatic logic prot_hit(input logic [19:0] a, input logic [4:0] lvl,
                                    input logic cmp);
    logic [4:0] blocks;
    logic [4:0] blk;
    logic hit;
    blk = {1'b0, a[`SFE_MEM_TOP:`SFE_B64_LSB]};
    if (lvl[2:0] == 3'h0) begin
      blocks = 5'h00;
    end else if (lvl[2:0] >= `SFE_LVL_ALL) begin
      blocks = `SFE_BLOCKS;
    end else begin
      blocks = 5'h01 << (lvl[2:0] - 3'h1);
    end
    if (lvl[3]) begin
      hit = blk < blocks;
    end else begin
      hit = blk >= (`SFE_BLOCKS - blocks);
    end
    return hit ^ cmp;
  endfunction : prot_hit

  // A unit is protected when either end of it lies in the protected area.
  function automatic logic unit_locked(input logic [19:0] a, input sfe_pkg::sfe_wipe_type k,
                                       input logic [4:0] lvl, input logic cmp);
    logic [19:0] first;
    first = a & ~unit_mask(k);
    return prot_hit(first, lvl, cmp) || prot_hit(first | unit_mask(k), lvl, cmp);
  endfunction : unit_locked

  function automatic logic [31:0] wipe_cycles(input sfe_pkg::sfe_wipe_type k);
    logic [31:0] c;
    c = 32'(BLOCK_CYC - 1);
    case (k)
      sfe_pkg::SFE_W4K: c = 32'(SMALL_CYC - 1);
      sfe_pkg::SFE_WALL: c = 32'(FULL_CYC - 1);
      default: c = 32'(BLOCK_CYC - 1);
    endcase
    return c;
  endfunction : wipe_cycles

  // ****************************************
  // Link sampling and bit shifter
  // ****************************************
  logic cs_s;
  logic sclk_s;
  logic si_s;
  logic cs_q_ff;
  logic sclk_q_ff;
  logic [31:0] shift_ff;
  logic [5:0] cnt_ff;

  sfe_sync #(.W(3), .RST_VAL(3'b100)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link.cs_n, link.sclk, link.si}),
    .q({cs_s, sclk_s, si_s})
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_q_ff <= 1'b1;
      sclk_q_ff <= 1'b0;
    end else begin
      cs_q_ff <= cs_s;
      sclk_q_ff <= sclk_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_ff <= 32'h0;
      cnt_ff <= 6'h00;
    end else if (cs_s) begin
      cnt_ff <= 6'h00;
    end else if (sclk_s && !sclk_q_ff) begin
      shift_ff <= {shift_ff[30:0], si_s};
      if (cnt_ff != `SFE_BIT_SAT) begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // ****************************************
  // Command decode at the end of a frame
  // ****************************************
  sfe_pkg::sfe_dev_type state_ff;
  logic [31:0] timer_ff;
  logic wel_ff;
  logic armed_ff;
  logic frame_end;
  logic short_ok;
  logic long_ok;
  logic [7:0] op8;
  logic [7:0] op32;
  logic go_wipe;
  logic go_sleep;
  logic go_wake;
  logic go_soft_rst;
  sfe_pkg::sfe_wipe_type go_kind;

  always_comb begin
    frame_end = cs_s && !cs_q_ff;
    short_ok = frame_end && (cnt_ff == `SFE_OP_BITS);
    long_ok = frame_end && (cnt_ff == `SFE_ADDR_BITS);
    op8 = shift_ff[7:0];
    op32 = shift_ff[`SFE_OP_MSB:`SFE_OP_LSB];
    go_wipe = 1'b0;
    go_kind = sfe_pkg::SFE_WALL;
    if (long_ok && op32 == `SFE_OP_SMALL_WIPE) begin
      go_wipe = 1'b1;
      go_kind = sfe_pkg::SFE_W4K;
    end else if (long_ok && op32 == `SFE_OP_WIPE32) begin
      go_wipe = 1'b1;
      go_kind = sfe_pkg::SFE_W32K;
    end else if (long_ok && op32 == `SFE_OP_WIPE64) begin
      go_wipe = 1'b1;
      go_kind = sfe_pkg::SFE_W64K;
    end else if (short_ok && (op8 == `SFE_OP_FULL_A || op8 == `SFE_OP_FULL_B)) begin
      go_wipe = 1'b1;
      go_kind = sfe_pkg::SFE_WALL;
    end
    if (unit_locked(shift_ff[19:0], go_kind, protect_level_bits, protect_complement)) begin
      go_wipe = 1'b0;
    end
    go_wipe = go_wipe && wel_ff && (state_ff == sfe_pkg::SFE_STANDBY);
    go_sleep = short_ok && op8 == `SFE_OP_LOWEST && state_ff == sfe_pkg::SFE_STANDBY;
    go_soft_rst = short_ok && op8 == `SFE_OP_RST && armed_ff;
    go_wake = (short_ok && op8 == `SFE_OP_WAKE) || go_soft_rst;
  end

  // ****************************************
  // Device state and cycle timer
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= sfe_pkg::SFE_STANDBY;
      timer_ff <= 32'h0;
    end else begin
      case (state_ff)
        sfe_pkg::SFE_STANDBY: begin
          if (go_wipe) begin
            state_ff <= sfe_pkg::SFE_WIPING;
            timer_ff <= wipe_cycles(go_kind);
          end else if (go_sleep) begin
            state_ff <= sfe_pkg::SFE_SLEEP_WAIT;
            timer_ff <= 32'(SLEEP_CYC - 1);
          end
        end
        sfe_pkg::SFE_WIPING: begin
          if (timer_ff == 32'h0) begin
            state_ff <= sfe_pkg::SFE_STANDBY;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
        sfe_pkg::SFE_SLEEP_WAIT: begin
          if (go_wake) begin
            state_ff <= sfe_pkg::SFE_STANDBY;
          end else if (timer_ff == 32'h0) begin
            state_ff <= sfe_pkg::SFE_SLEEPING;
          end else begin
            timer_ff <= timer_ff - 32'h1;
          end
        end
        sfe_pkg::SFE_SLEEPING: begin
          if (go_wake) begin
            state_ff <= sfe_pkg::SFE_STANDBY;
          end
        end
        default: state_ff <= sfe_pkg::SFE_STANDBY;
      endcase
    end
  end

  // ****************************************
  // Write latch and reset arming
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wel_ff <= 1'b0;
    end else if (go_wipe || go_soft_rst) begin
      wel_ff <= 1'b0;
    end else if (short_ok && state_ff == sfe_pkg::SFE_STANDBY) begin
      if (op8 == `SFE_OP_UNLOCK) begin
        wel_ff <= 1'b1;
      end else if (op8 == `SFE_OP_LOCK) begin
        wel_ff <= 1'b0;
      end
    end
  end

  // The reset pair must be two back-to-back frames; any other frame disarms.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_ff <= 1'b0;
    end else if (frame_end) begin
      armed_ff <= short_ok && op8 == `SFE_OP_RST_EN && state_ff != sfe_pkg::SFE_WIPING;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic busy_ff;
  logic asleep_ff;
  logic wipe_start_ff;
  logic [1:0] wipe_kind_ff;
  logic [19:0] wipe_base_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_ff <= 1'b0;
      asleep_ff <= 1'b0;
      wipe_start_ff <= 1'b0;
      wipe_kind_ff <= 2'h0;
      wipe_base_ff <= 20'h0;
    end else begin
      busy_ff <= state_ff == sfe_pkg::SFE_WIPING;
      asleep_ff <= state_ff == sfe_pkg::SFE_SLEEPING;
      wipe_start_ff <= go_wipe;
      if (go_wipe) begin
        wipe_kind_ff <= go_kind;
        wipe_base_ff <= shift_ff[19:0] & ~unit_mask(go_kind);
      end
    end
  end

  assign busy_flag = busy_ff;
  assign write_latch_flag = wel_ff;
  assign asleep = asleep_ff;
  assign wipe_start = wipe_start_ff;
  assign wipe_kind = wipe_kind_ff;
  assign wipe_base = wipe_base_ff;
endmodule : sfe_flash_dev

// ### sfe_host.sv
// Host controller end: AXI4-Lite command registers driving the serial link.
`include "sfe_regs.svh"
module sfe_host #(
  parameter int CLK_MHZ = `SFE_CLK_MHZ,
  parameter int HALF_CYC = `SFE_HALF_CYC,
  parameter int GAP_NS = `SFE_GAP_NS,
  parameter int RELEASE_NS = `SFE_RELEASE_NS
) (
  input logic aclk, // Core clock.
  input logic aresetn, // Synchronous reset, active low.
  input logic [3:0] s_axi_awaddr, // Write address.
  input logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input logic [31:0] s_axi_wdata, // Write data.
  input logic [3:0] s_axi_wstrb, // Write byte strobes.
  input logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input logic s_axi_bready, // Write response ready.
  input logic [3:0] s_axi_araddr, // Read address.
  input logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input logic s_axi_rready, // Read data ready.
  sfe_link_if.host link // Serial link to the flash.
);
  localparam int GAP_CYC = (GAP_NS * CLK_MHZ + `SFE_NS_PER_US - 1) / `SFE_NS_PER_US;
  localparam int REL_CYC = (RELEASE_NS * CLK_MHZ + `SFE_NS_PER_US - 1) / `SFE_NS_PER_US;

  if (HALF_CYC < 1 || GAP_CYC < 1 || REL_CYC < 1) begin : g_chk
    $error("sfe_host: link timings need at least one cycle");
  end

  // ****************************************
  // AXI4-Lite write and read channels
  // ****************************************
  logic aw_got_ff;
  logic w_got_ff;
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [23:0] addr_ff;
  logic [7:0] op_ff;
  logic wr_fire;
  logic launch;
  logic [1:0] wr_resp;
  sfe_pkg::sfe_host_type hst_ff;

  always_comb begin
    wr_fire = aw_got_ff && w_got_ff && !bvalid_ff;
    launch = 1'b0;
    wr_resp = `SFE_RESP_OK;
    case (awaddr_ff)
      `SFE_REG_CMD: begin
        if (wstrb_ff[0] && hst_ff == sfe_pkg::SFE_H_IDLE) begin
          launch = wr_fire;
        end else begin
          wr_resp = `SFE_RESP_ERR;
        end
      end
      `SFE_REG_ADDR: wr_resp = `SFE_RESP_OK;
      `SFE_REG_STAT: wr_resp = `SFE_RESP_OK;
      default: wr_resp = `SFE_RESP_ERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else begin
      awready_ff <= s_axi_awvalid && !aw_got_ff && !awready_ff;
      wready_ff <= s_axi_wvalid && !w_got_ff && !wready_ff;
      if (s_axi_awvalid && awready_ff) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_got_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `SFE_RESP_OK;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_ff <= 24'h0;
    end else if (wr_fire && awaddr_ff == `SFE_REG_ADDR) begin
      for (int i = 0; i < 3; i++) begin
        if (wstrb_ff[i]) begin
          addr_ff[i*8 +: 8] <= wdata_ff[i*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `SFE_RESP_OK;
    end else begin
      arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
      if (s_axi_arvalid && arready_ff) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= `SFE_RESP_OK;
        case (s_axi_araddr)
          `SFE_REG_CMD: rdata_ff <= {24'h0, op_ff};
          `SFE_REG_ADDR: rdata_ff <= {8'h0, addr_ff};
          `SFE_REG_STAT: rdata_ff <= {31'h0, hst_ff != sfe_pkg::SFE_H_IDLE};
          default: begin
            rdata_ff <= 32'h0;
            rresp_ff <= `SFE_RESP_ERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Serial link engine
  // ****************************************
  logic cs_n_ff;
  logic sclk_ff;
  logic si_ff;
  logic [31:0] tx_ff;
  logic [5:0] bits_ff;
  logic [31:0] tmr_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hst_ff <= sfe_pkg::SFE_H_IDLE;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      si_ff <= 1'b0;
      tx_ff <= 32'h0;
      bits_ff <= 6'h00;
      tmr_ff <= 32'h0;
      op_ff <= 8'h00;
    end else begin
      case (hst_ff)
        sfe_pkg::SFE_H_IDLE: begin
          if (launch) begin
            cs_n_ff <= 1'b0;
            op_ff <= wdata_ff[7:0];
            tx_ff <= {wdata_ff[7:0], addr_ff};
            si_ff <= wdata_ff[7];
            bits_ff <= wdata_ff[`SFE_CMD_WITH_ADDR] ? `SFE_ADDR_BITS : `SFE_OP_BITS;
            tmr_ff <= 32'(HALF_CYC - 1);
            hst_ff <= sfe_pkg::SFE_H_LOW;
          end
        end
        sfe_pkg::SFE_H_LOW: begin
          if (tmr_ff == 32'h0) begin
            sclk_ff <= 1'b1;
            tmr_ff <= 32'(HALF_CYC - 1);
            hst_ff <= sfe_pkg::SFE_H_HIGH;
          end else begin
            tmr_ff <= tmr_ff - 32'h1;
          end
        end
        sfe_pkg::SFE_H_HIGH: begin
          if (tmr_ff == 32'h0) begin
            sclk_ff <= 1'b0;
            tx_ff <= {tx_ff[30:0], 1'b0};
            bits_ff <= bits_ff - 6'h01;
            tmr_ff <= 32'(HALF_CYC - 1);
            if (bits_ff == 6'h01) begin
              hst_ff <= sfe_pkg::SFE_H_TAIL;
            end else begin
              si_ff <= tx_ff[30];
              hst_ff <= sfe_pkg::SFE_H_LOW;
            end
          end else begin
            tmr_ff <= tmr_ff - 32'h1;
          end
        end
        sfe_pkg::SFE_H_TAIL: begin
          if (tmr_ff == 32'h0) begin
            cs_n_ff <= 1'b1;
            tmr_ff <= (op_ff == `SFE_OP_WAKE) ? 32'(REL_CYC - 1) : 32'(GAP_CYC - 1);
            hst_ff <= sfe_pkg::SFE_H_GAP;
          end else begin
            tmr_ff <= tmr_ff - 32'h1;
          end
        end
        sfe_pkg::SFE_H_GAP: begin
          if (tmr_ff == 32'h0) begin
            hst_ff <= sfe_pkg::SFE_H_IDLE;
          end else begin
            tmr_ff <= tmr_ff - 32'h1;
          end
        end
        default: hst_ff <= sfe_pkg::SFE_H_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign link.cs_n = cs_n_ff;
  assign link.sclk = sclk_ff;
  assign link.si = si_ff;
endmodule : sfe_host

// ### sfe_monitor.sv
// Checker of the serial link timing between host and flash ends.
module sfe_monitor (
  input logic aclk, // Core clock.
  input logic aresetn, // Reset, active low.
  input logic cs_n, // Chip select.
  input logic sclk, // Serial clock.
  input logic si // Serial data.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] bits_ff;
  logic [9:0] gap_ff;
  logic [7:0] sh_ff;
  logic sclk_ff;
  logic wake_ff;
  always_ff @(posedge aclk) begin
    sclk_ff <= aresetn && sclk;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || cs_n) begin
      bits_ff <= 6'h00;
    end else if (sclk && !sclk_ff && bits_ff != 6'h3F) begin
      bits_ff <= bits_ff + 6'h01;
      sh_ff <= {sh_ff[6:0], si};
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_ff <= 1'h0;
    end else if ($rose(cs_n)) begin
      wake_ff <= bits_ff == 6'h08 && sh_ff == 8'hAB;
    end
  end
  // Power-up counts as a long idle time, so the first frame is never short of gap.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_ff <= 10'h3FF;
    end else if (!cs_n) begin
      gap_ff <= 10'h000;
    end else if (gap_ff != 10'h3FF) begin
      gap_ff <= gap_ff + 10'h001;
    end
  end
  // ****
  // Link assertions.
  // ****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_SI_HOLD: assert property (sclk && sclk_ff |-> $stable(si))
    else $error("si moved while sclk high");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("sclk high outside frame");
  AST_HIGH_LEN: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("sclk high phase wrong");
  AST_LOW_LEN: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("sclk low phase short");
  AST_FIRST_BIT: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first sclk rise misplaced");
  AST_CS_RISE: assert property ($rose(cs_n) |-> !$past(sclk, 8) && !$past(sclk))
    else $error("select rose inside a bit");
  AST_COUNT: assert property ($rose(cs_n) |-> bits_ff == 6'h08 || bits_ff == 6'h20)
    else $error("frame bit count wrong");
  AST_GAP: assert property ($fell(cs_n) |-> gap_ff >= (wake_ff ? 10'h258 : 10'h014))
    else $error("select high time too short");
endmodule : sfe_monitor

// ### sfe_bench.sv
// Bench joining host and flash ends over the serial link.
`include "sfe_regs.svh"
module sfe_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awv, wv, brd, arv, rrd, awr, wrd, bv, arr, rv, cmp, sc, cq;
  logic busy, latch, slp, ws, busy2, slp2, ws2;
  logic [1:0] br, rr, wk, wk2;
  logic [3:0] awa, ara, stb;
  logic [4:0] lvl;
  logic [19:0] wb, wb2;
  logic [23:0] adr;
  logic [31:0] wd, rd, rnd;
  logic [33:0] s;
  logic [37:0] fr;
  int err_count, compares, bc;
  logic [22:0] wq[$];
  logic [37:0] fq[$];
  sfe_link_if lk();
  sfe_link_if lk2();
  sfe_host sfe_host_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(stb), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .link(lk.host));
  sfe_flash_dev #(.SMALL_WIPE_US(1), .BLOCK_WIPE_US(2), .FULL_WIPE_US(3), .SLEEP_ENTRY_NS(50))
    sfe_flash_dev_i (.aclk(aclk), .aresetn(aresetn), .link(lk.flash), .protect_level_bits(lvl),
    .protect_complement(cmp), .busy_flag(busy), .write_latch_flag(latch), .asleep(slp),
    .wipe_start(ws), .wipe_kind(wk), .wipe_base(wb));
  sfe_flash_dev #(.SMALL_WIPE_US(1))
    sfe_flash_dev_i2 (.aclk(aclk), .aresetn(aresetn), .link(lk2.flash), .protect_level_bits(lvl),
    .protect_complement(cmp), .busy_flag(busy2), .write_latch_flag(), .asleep(slp2),
    .wipe_start(ws2), .wipe_kind(wk2), .wipe_base(wb2));
  sfe_monitor sfe_monitor_i (.aclk(aclk), .aresetn(aresetn), .cs_n(lk.cs_n), .sclk(lk.sclk),
    .si(lk.si));
  task automatic chk(input logic [37:0] g, e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic finish_test;
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    awa <= a;
    wd <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    brd <= 1'h1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
      if (bv) begin
        brd <= 1'h0;
        chk(br, r);
      end
    end while (awv || wv || brd);
  endtask : wr
  task automatic rdr(input logic [3:0] a, output logic [33:0] d);
    ara <= a;
    arv <= 1'h1;
    rrd <= 1'h1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'h0;
      if (rv) begin
        rrd <= 1'h0;
        d = {rr, rd};
      end
    end while (arv || rrd);
  endtask : rdr
  task automatic idle;
    logic [33:0] t;
    t = 34'h1;
    while (t[0]) rdr(`SFE_REG_STAT, t);
  endtask : idle
  task automatic cmd(input logic [8:0] op);
    idle();
    fq.push_back(op[8] ? {6'h20, op[7:0], adr} : {6'h08, 24'h0, op[7:0]});
    wr(`SFE_REG_CMD, {23'h0, op}, `SFE_RESP_OK);
  endtask : cmd
  task automatic er(input logic [8:0] op, input logic [19:0] ta, input logic [1:0] k,
      input logic [4:0] l, input logic c, u, ok);
    lvl <= l;
    cmp <= c;
    rnd = xs(rnd);
    adr = {4'h0, ta | (rnd[19:0] & (20'hFFFFF >> (k == 2'h0 ? 8 : k == 2'h1 ? 5 : 4)))};
    wr(`SFE_REG_ADDR, {8'h0, adr}, `SFE_RESP_OK);
    if (u) cmd(9'h006);
    if (ok) wq.push_back({1'h0, k, ta});
    cmd(op);
    idle();
    while (busy) @(posedge aclk);
  endtask : er
  // Bit-bangs a frame at an 80 ns link clock, so broken framing can be sent.
  task automatic bb(input logic [32:0] v, input int n);
    lk2.cs_n <= 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      lk2.si <= v[i];
      repeat (8) @(posedge aclk);
      lk2.sclk <= 1'h1;
      repeat (8) @(posedge aclk);
      lk2.sclk <= 1'h0;
    end
    repeat (8) @(posedge aclk);
    lk2.cs_n <= 1'h1;
    lk2.si <= !v[0];
    repeat (8) @(posedge aclk);
  endtask : bb
  always @(posedge aclk) begin
    if (ws || ws2) begin
      if (wq.size() == 0) chk(1, 0);
      else chk({ws2, ws2 ? {wk2, wb2} : {wk, wb}}, wq.pop_front());
    end
    if (busy) bc++;
    else if (bc != 0) begin
      chk(bc, (wk == 2'h0 ? 1 : wk == 2'h3 ? 3 : 2) * `SFE_CLK_MHZ);
      chk(latch, 1'h0);
      bc = 0;
    end
    if (lk.sclk && !sc) fr = {fr[37:32] + 6'h01, fr[30:0], lk.si};
    if (lk.cs_n && !cq && fq.size() != 0) chk(fr, fq.pop_front());
    if (lk.cs_n) fr = '0;
    sc = lk.sclk;
    cq = lk.cs_n;
  end
  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (80000) @(posedge aclk);
    err_count++;
    finish_test();
  end
  initial begin
    {aresetn, awv, wv, brd, arv, rrd, cmp, lvl, awa, ara, wd, adr} = '0;
    {lk2.cs_n, lk2.sclk, lk2.si} = 3'h4;
    rnd = 32'hB36BFDE4;
    stb = 4'hF;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    er(9'h120, 20'h3A000, 2'h0, 5'h00, 1'h0, 1'h1, 1'h1);
    er(9'h152, 20'h58000, 2'h1, 5'h00, 1'h0, 1'h1, 1'h1);
    er(9'h1D8, 20'h70000, 2'h2, 5'h00, 1'h0, 1'h1, 1'h1);
    er(9'h120, 20'h3A000, 2'h0, 5'h00, 1'h0, 1'h0, 1'h0);
    er(9'h060, 20'h00000, 2'h3, 5'h00, 1'h0, 1'h1, 1'h1);
    er(9'h0C7, 20'h00000, 2'h3, 5'h01, 1'h0, 1'h1, 1'h0);
    er(9'h120, 20'hF3000, 2'h0, 5'h01, 1'h0, 1'h1, 1'h0);
    er(9'h152, 20'hF8000, 2'h1, 5'h01, 1'h0, 1'h1, 1'h0);
    er(9'h1D8, 20'hE0000, 2'h2, 5'h01, 1'h0, 1'h1, 1'h1);
    er(9'h0C7, 20'h00000, 2'h3, 5'h07, 1'h1, 1'h1, 1'h1);
    wq.push_back({1'h0, 2'h3, 20'h00000});
    cmd(9'h006);
    cmd(9'h060);
    cmd(9'h0B9);
    while (busy) @(posedge aclk);
    chk(slp, 1'h0);
    cmd(9'h0B9);
    er(9'h120, 20'h10000, 2'h0, 5'h00, 1'h0, 1'h1, 1'h0);
    chk(slp, 1'h1);
    cmd(9'h0AB);
    idle();
    chk(slp, 1'h0);
    cmd(9'h0B9);
    cmd(9'h066);
    chk(slp, 1'h1);
    cmd(9'h099);
    idle();
    chk(slp, 1'h0);
    cmd(9'h0B9);
    idle();
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(slp, 1'h0);
    wr(4'hC, 32'h0, `SFE_RESP_ERR);
    rdr(4'hC, s);
    chk(s, {`SFE_RESP_ERR, 32'h0});
    stb <= 4'hE;
    wr(`SFE_REG_CMD, 32'h0B9, `SFE_RESP_ERR);
    stb <= 4'hF;
    rdr(`SFE_REG_STAT, s);
    chk(s, 34'h0);
    adr = {12'h045, rnd[11:0]};
    bb(33'h006, 8);
    bb({9'h020, adr[23:1]}, 31);
    bb({8'h20, adr, 1'h0}, 33);
    bb({24'h0, 8'hC7, 1'h0}, 9);
    wq.push_back({1'h1, 2'h0, 20'h45000});
    bb({1'h0, 8'h20, adr}, 32);
    while (busy2) @(posedge aclk);
    bb(33'h05C, 7);
    bb(33'h0B9, 8);
    chk(slp2, 1'h0);
    repeat (600) @(posedge aclk);
    chk(slp2, 1'h1);
    bb(33'h0AB, 8);
    chk(slp2, 1'h0);
    chk(wq.size(), 0);
    finish_test();
  end
endmodule : sfe_bench
